// >>> hw/srl_ctrl_end.sv
/*
 * controller end: AXI4-Lite registers steer commands and limit values.
 * assumes: one aclk shared with the drive end.
 */
`timescale 1ns/1ns
`include "srl_defines.svh"
module srl_ctrl_end (
    input wire logic aclk,
    input wire logic aresetn,
    srl_link_if.ctrl link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import srl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // write channel capture
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic do_write;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    srl_mode_e mode_q;
    srl_mode_e wmode;
    logic limit_active;
    logic toward;
    logic signed [31:0] delta;
    assign wmode = srl_mode_e'(wdata_q[`SRL_CTRL_MODE_LSB +: 3]);
    assign limit_active = !link.upper_travel_limit || !link.lower_travel_limit;
    // csv judges the sign, every other mode the step from actual
    assign delta = (mode_q == SRL_CSV) ? $signed(wdata_q) :
        $signed(wdata_q - link.act_pos);
    assign toward = (!link.upper_travel_limit && delta > 0) ||
        (!link.lower_travel_limit && delta < 0); // RULE14 RULE15 RULE16
    logic cmd_refused;
    assign cmd_refused = awaddr_q == `SRL_OFS_CMD &&
        ((link.travel_end && link.follow_pending) || toward); // RULE7 RULE12

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= SRL_CSP;
            link.cmd_pos <= '0;
            link.cmd_valid <= 1'b0;
            link.ctrl_upper_limit_in <= 1'b1;
            link.ctrl_lower_limit_in <= 1'b1;
            link.ctrl_home_in <= 1'b0;
            link.home_req <= 1'b0;
            link.alarm_reset <= 1'b0;
        end else begin
            link.cmd_valid <= 1'b0;
            link.home_req <= 1'b0;
            link.alarm_reset <= 1'b0;
            if (do_write && awaddr_q == `SRL_OFS_CTRL) begin
                if (wmode == SRL_CSPR && limit_active) begin
                    mode_q <= SRL_CSP; // RULE13
                end else begin
                    mode_q <= wmode;
                end
                link.home_req <= wdata_q[`SRL_CTRL_HOME_REQ];
                link.alarm_reset <= wdata_q[`SRL_CTRL_ALM_RST];
                if (wdata_q[`SRL_CTRL_FOLLOW]) begin
                    link.cmd_pos <= link.act_pos; // RULE11
                    link.cmd_valid <= 1'b1;
                end
            end
            if (do_write && !cmd_refused && awaddr_q == `SRL_OFS_CMD) begin
                link.cmd_pos <= wdata_q;
                link.cmd_valid <= 1'b1;
            end
            if (do_write && awaddr_q == `SRL_OFS_LIMIT) begin
                link.ctrl_upper_limit_in <= wdata_q[`SRL_LIM_UPPER]; // RULE3
                link.ctrl_lower_limit_in <= wdata_q[`SRL_LIM_LOWER]; // RULE3
                link.ctrl_home_in <= wdata_q[`SRL_LIM_HOME];
            end
        end
    end
    assign link.csp_mode = (mode_q == SRL_CSP);

    ////////////////////////////////////////////////////////////////////////
    // write response
    logic wr_mapped;
    assign wr_mapped = awaddr_q == `SRL_OFS_CTRL || awaddr_q == `SRL_OFS_LIMIT ||
        (awaddr_q == `SRL_OFS_CMD && !cmd_refused);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SRL_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `SRL_RESP_OKAY : `SRL_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic [31:0] rd_mux;
    logic rd_ok;
    assign s_axi_arready = !s_axi_rvalid;
    always_comb begin
        rd_ok = 1'b1;
        rd_mux = '0;
        case (s_axi_araddr)
            `SRL_OFS_CTRL: rd_mux = {29'h0, mode_q};
            `SRL_OFS_CMD: rd_mux = link.cmd_pos;
            `SRL_OFS_LIMIT: rd_mux = {29'h0, link.ctrl_home_in,
                link.ctrl_lower_limit_in, link.ctrl_upper_limit_in};
            `SRL_OFS_STATUS: rd_mux = {24'h0, link.follow_pending, link.abs_pos_lost_flag,
                link.homed, link.command_error_alarm, link.travel_end, link.home_prox,
                link.lower_travel_limit, link.upper_travel_limit};
            `SRL_OFS_ACTPOS: rd_mux = link.act_pos;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `SRL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `SRL_RESP_OKAY : `SRL_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // srl_ctrl_end

// >>> hw/srl_defines.svh
/*
 * offsets, field positions, reset values and counts of the stroke limit pair.
 * assumes: included by bare name.
 */
`ifndef SRL_DEFINES_SVH
`define SRL_DEFINES_SVH
`define SRL_OFS_CTRL 8'h00
`define SRL_OFS_CMD 8'h04
`define SRL_OFS_LIMIT 8'h08
`define SRL_OFS_STATUS 8'h0c
`define SRL_OFS_ACTPOS 8'h10
`define SRL_CTRL_MODE_LSB 0
`define SRL_CTRL_HOME_REQ 4
`define SRL_CTRL_ALM_RST 5
`define SRL_CTRL_FOLLOW 6
`define SRL_LIM_UPPER 0
`define SRL_LIM_LOWER 1
`define SRL_LIM_HOME 2
`define SRL_RESP_OKAY 2'h0
`define SRL_RESP_SLVERR 2'h2
`define SRL_OVERRUN_PULSES 32'sh0000001e
`define SRL_ABS_SEL_RST 1'h0
`endif

// >>> hw/srl_drive_end.sv
/*
 * drive end: limit source select, direction mapping, stop and command error.
 * assumes: pins asynchronous; link signals on aclk from the controller end.
 */
// Contract
// RULE1 - source 0: limits from own pins
// RULE2 - source 1: limits from controller values
// RULE3 - controller sends increasing-side switch as upper
// RULE4 - direction 0: forward end reported upper
// RULE5 - direction 1: reverse end reported upper
// RULE6 - any limit off stops the motor
// RULE7 - csp: controller stops command at travel end
// RULE8 - csp: overrun by 30 raises command error
// RULE9 - command error clears home position
// RULE10 - select 1: command error sets absolute-lost
// RULE11 - csp recovery: follow, bit12 zero, move away
// RULE12 - csv recovery: bit12 zero, velocity away
// RULE13 - pressure mode: switch to csp first
// RULE14 - profile position: target opposite to limit
// RULE15 - point table: move opposite to limit
// RULE16 - jog: jog opposite to limit
// RULE17 - auto-on ends never stop the motor
// RULE18 - contact closed releases, open limits
// RULE19 - absolute-lost select defaults disabled
// RULE20 - limits re-evaluated every clock
`timescale 1ns/1ns
`include "srl_defines.svh"
module srl_drive_end (
    input wire logic aclk,
    input wire logic aresetn,
    srl_link_if.dev link,
    input wire logic fwd_travel_end,
    input wire logic rev_travel_end,
    input wire logic home_prox_pin,
    input wire logic sensor_source_select,
    input wire logic direction_select,
    input wire logic cmd_err_abs_flag_select,
    input wire logic auto_on_select,
    output logic motor_stop,
    output srl_pkg::srl_state_e stop_state
);
    import srl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_raw;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    assign pin_raw = {home_prox_pin, rev_travel_end, fwd_travel_end};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_q[gi] <= 1'b1;
                    s2_q[gi] <= 1'b1;
                end else begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // limit selection and mapping
    logic fwd_ok;
    logic rev_ok;
    logic up_ok;
    logic lo_ok;
    logic home_on;
    logic abs_sel_q;
    // high level means contact closed, limit released
    assign fwd_ok = auto_on_select | s2_q[0]; // RULE17 RULE18
    assign rev_ok = auto_on_select | s2_q[1]; // RULE17 RULE18
    always_comb begin
        if (sensor_source_select) begin
            up_ok = link.ctrl_upper_limit_in; // RULE2 RULE3
            lo_ok = link.ctrl_lower_limit_in; // RULE2
            home_on = link.ctrl_home_in; // RULE2
        end else begin
            up_ok = direction_select ? rev_ok : fwd_ok; // RULE1 RULE4 RULE5
            lo_ok = direction_select ? fwd_ok : rev_ok; // RULE1 RULE4 RULE5
            home_on = s2_q[2]; // RULE1
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.upper_travel_limit <= 1'b1;
            link.lower_travel_limit <= 1'b1;
            link.home_prox <= 1'b0;
            abs_sel_q <= `SRL_ABS_SEL_RST; // RULE19
        end else begin
            link.upper_travel_limit <= up_ok; // RULE20
            link.lower_travel_limit <= lo_ok; // RULE20
            link.home_prox <= home_on;
            abs_sel_q <= cmd_err_abs_flag_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stop state machine
    srl_state_e state_q;
    srl_state_e state_d;
    srl_pos_t det_pos_q;
    logic limit_off;
    logic overrun;
    logic signed [31:0] up_over;
    logic signed [31:0] lo_over;
    assign limit_off = !up_ok || !lo_ok;
    assign up_over = $signed(link.cmd_pos - det_pos_q);
    assign lo_over = $signed(det_pos_q - link.cmd_pos);
    assign overrun = link.csp_mode &&
        ((!up_ok && up_over > `SRL_OVERRUN_PULSES) ||
         (!lo_ok && lo_over > `SRL_OVERRUN_PULSES)); // RULE7 RULE8

    always_comb begin
        state_d = state_q;
        case (state_q)
            SRL_RUN: begin
                if (limit_off) begin
                    state_d = SRL_STOP; // RULE6 RULE20
                end
            end
            SRL_STOP: begin
                if (overrun) begin
                    state_d = SRL_ALARM; // RULE8
                end else if (!limit_off) begin
                    state_d = SRL_RUN;
                end
            end
            SRL_ALARM: begin
                if (link.alarm_reset) begin
                    state_d = limit_off ? SRL_STOP : SRL_RUN;
                end
            end
            default: begin
                state_d = SRL_STOP;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SRL_STOP;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_pos_q <= '0;
        end else if (state_q == SRL_RUN && limit_off) begin
            det_pos_q <= link.act_pos;
        end
    end

    assign motor_stop = (state_q != SRL_RUN);
    assign stop_state = state_q;
    assign link.travel_end = (state_q != SRL_RUN);
    assign link.command_error_alarm = (state_q == SRL_ALARM);

    ////////////////////////////////////////////////////////////////////////
    // position follow: only moves away from an open limit while stopped
    logic away;
    assign away = (up_ok || $signed(link.cmd_pos - link.act_pos) < 0) &&
        (lo_ok || $signed(link.cmd_pos - link.act_pos) > 0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.act_pos <= '0;
        end else if (link.cmd_valid) begin
            if (state_q == SRL_RUN && !limit_off) begin
                link.act_pos <= link.cmd_pos;
            end else if (state_q == SRL_STOP && away && !link.follow_pending) begin
                link.act_pos <= link.cmd_pos; // RULE11 RULE14 RULE15 RULE16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // follow-up flag seen by the controller as statusword bit 12
    logic enter_stop;
    assign enter_stop = state_q == SRL_RUN && limit_off;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.follow_pending <= 1'b0;
        end else if (enter_stop && link.csp_mode) begin
            link.follow_pending <= 1'b1; // RULE11
        end else if (link.cmd_pos == link.act_pos) begin
            link.follow_pending <= 1'b0; // RULE11 RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // home position and absolute-lost flag
    logic alarm_entry;
    assign alarm_entry = state_q == SRL_STOP && state_d == SRL_ALARM;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.homed <= 1'b0;
        end else if (alarm_entry) begin
            link.homed <= 1'b0; // RULE9
        end else if (link.home_req && home_on && state_q != SRL_ALARM) begin
            link.homed <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.abs_pos_lost_flag <= 1'b0;
        end else if (alarm_entry && abs_sel_q) begin
            link.abs_pos_lost_flag <= 1'b1; // RULE10 RULE19
        end else if (link.home_req && home_on && state_q != SRL_ALARM) begin
            link.abs_pos_lost_flag <= 1'b0;
        end
    end
endmodule // srl_drive_end

// >>> hw/srl_link_if.sv
/*
 * link between motion controller and drive.
 * assumes: both ends on aclk.
 */
`timescale 1ns/1ns
interface srl_link_if (input logic aclk);
    logic csp_mode;
    srl_pkg::srl_pos_t cmd_pos;
    logic cmd_valid;
    logic ctrl_upper_limit_in;
    logic ctrl_lower_limit_in;
    logic ctrl_home_in;
    logic home_req;
    logic alarm_reset;
    logic upper_travel_limit;
    logic lower_travel_limit;
    logic home_prox;
    logic travel_end;
    logic command_error_alarm;
    logic abs_pos_lost_flag;
    logic homed;
    logic follow_pending;
    srl_pkg::srl_pos_t act_pos;
    modport dev (
        input csp_mode, cmd_pos, cmd_valid, ctrl_upper_limit_in, ctrl_lower_limit_in,
        input ctrl_home_in, home_req, alarm_reset,
        output upper_travel_limit, lower_travel_limit, home_prox, travel_end,
        output command_error_alarm, abs_pos_lost_flag, homed, follow_pending, act_pos
    );
    modport ctrl (
        output csp_mode, cmd_pos, cmd_valid, ctrl_upper_limit_in, ctrl_lower_limit_in,
        output ctrl_home_in, home_req, alarm_reset,
        input upper_travel_limit, lower_travel_limit, home_prox, travel_end,
        input command_error_alarm, abs_pos_lost_flag, homed, follow_pending, act_pos
    );
endinterface

// >>> hw/srl_pkg.sv
/*
 * types shared by both ends of the stroke limit link.
 * assumes: nothing.
 */
package srl_pkg;
    typedef logic [31:0] srl_pos_t;
    typedef enum logic [2:0] {
        SRL_CSP = 3'b000,
        SRL_CSV = 3'b001,
        SRL_CSPR = 3'b010,
        SRL_PP = 3'b011,
        SRL_PT = 3'b100,
        SRL_JOG = 3'b101
    } srl_mode_e;
    typedef enum logic [1:0] {
        SRL_RUN = 2'b00,
        SRL_STOP = 2'b01,
        SRL_ALARM = 2'b10
    } srl_state_e;
endpackage

// >>> tb/srl_monitor.sv
/*
 * link checker for the stroke limit pair: timing of stop, alarm, homing.
 * assumes: instantiated beside the link interface, one clock, sync reset.
 */
`timescale 1ns/1ns
module srl_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic csp_mode,
    input wire logic alarm_reset,
    input wire logic home_req,
    input wire logic upper_travel_limit,
    input wire logic lower_travel_limit,
    input wire logic travel_end,
    input wire logic command_error_alarm,
    input wire logic abs_pos_lost_flag,
    input wire logic homed,
    input wire logic follow_pending,
    input wire srl_pkg::srl_pos_t act_pos
);
    import srl_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    upper_stop_a: assert property ($fell(upper_travel_limit) |=> travel_end)
        else $error("no stop after upper limit opened");
    lower_stop_a: assert property ($fell(lower_travel_limit) |=> travel_end)
        else $error("no stop after lower limit opened");
    resume_clear_a: assert property ($fell(travel_end) && !command_error_alarm
        |-> upper_travel_limit && lower_travel_limit)
        else $error("motion resumed with a limit open");
    alarm_from_stop_a: assert property ($rose(command_error_alarm) |-> $past(travel_end))
        else $error("command error raised outside a stop");
    alarm_home_a: assert property ($rose(command_error_alarm) |-> !homed)
        else $error("home kept after command error");
    abs_with_alarm_a: assert property ($rose(abs_pos_lost_flag)
        |-> $rose(command_error_alarm))
        else $error("absolute lost flag without command error");
    alarm_hold_a: assert property (command_error_alarm && !alarm_reset
        |=> command_error_alarm && $stable(act_pos))
        else $error("alarm left or axis moved without alarm reset");
    home_cause_a: assert property ($rose(homed) |-> $past(home_req))
        else $error("homed set without a homing request");
    follow_set_a: assert property ($rose(travel_end) && csp_mode |-> follow_pending)
        else $error("follow pending not raised at stop in csp");
endmodule // srl_monitor

// >>> tb/tb.sv
/*
 * bench for both ends: register tasks over AXI4-Lite, pins driven directly.
 * assumes: design ends joined through srl_link_if on one 250 MHz clock.
 */
`timescale 1ns/1ns
`include "srl_defines.svh"
module tb;
    import srl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic fwd_travel_end = 1'b1, rev_travel_end = 1'b1, home_prox_pin = 1'b1;
    logic sensor_source_select = 1'b0, direction_select = 1'b0;
    logic cmd_err_abs_flag_select = 1'b0, auto_on_select = 1'b0;
    logic motor_stop;
    srl_state_e stop_state;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, arready, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] d;
    logic [1:0] r;
    logic up, lo;
    int errors = 0, n_compared = 0, cyc = 0;
    always #2 aclk = ~aclk;
    srl_link_if u_srl_link_if (.aclk(aclk));
    srl_drive_end u_srl_drive_end (.aclk(aclk), .aresetn(aresetn), .link(u_srl_link_if),
        .fwd_travel_end(fwd_travel_end), .rev_travel_end(rev_travel_end),
        .home_prox_pin(home_prox_pin), .sensor_source_select(sensor_source_select),
        .direction_select(direction_select), .cmd_err_abs_flag_select(cmd_err_abs_flag_select),
        .auto_on_select(auto_on_select), .motor_stop(motor_stop), .stop_state(stop_state));
    srl_ctrl_end u_srl_ctrl_end (.aclk(aclk), .aresetn(aresetn), .link(u_srl_link_if),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    srl_monitor u_srl_monitor (.aclk(aclk), .aresetn(aresetn),
        .csp_mode(u_srl_link_if.csp_mode), .alarm_reset(u_srl_link_if.alarm_reset),
        .home_req(u_srl_link_if.home_req), .upper_travel_limit(u_srl_link_if.upper_travel_limit),
        .lower_travel_limit(u_srl_link_if.lower_travel_limit),
        .travel_end(u_srl_link_if.travel_end),
        .command_error_alarm(u_srl_link_if.command_error_alarm),
        .abs_pos_lost_flag(u_srl_link_if.abs_pos_lost_flag), .homed(u_srl_link_if.homed),
        .follow_pending(u_srl_link_if.follow_pending), .act_pos(u_srl_link_if.act_pos));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // handshakes judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rb;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rb = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        chk({30'h0, rb}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        logic t;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            t = arvalid && arready;
            @(posedge aclk);
            if (t) arvalid <= 1'b0;
        end while (!t);
        do begin
            @(negedge aclk);
            t = rvalid;
            v = rdata;
            rr = rresp;
            @(posedge aclk);
        end while (!t);
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rr;
        rd(`SRL_OFS_STATUS, v, rr);
        chk(v & m, e);
    endtask
    task automatic ms(input logic e);
        @(negedge aclk);
        chk({31'h0, motor_stop}, {31'h0, e});
        @(posedge aclk);
    endtask
    // overrun race: command lands on the edge that enters the stop, before the link limit and travel_end reach the controller end
    task automatic ov(input logic sel);
        aresetn <= 1'b0;
        sensor_source_select <= 1'b0;
        direction_select <= 1'b0;
        fwd_travel_end <= 1'b1;
        cmd_err_abs_flag_select <= sel;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        wr(`SRL_OFS_CTRL, 32'h10, `SRL_RESP_OKAY);
        st(32'h20, 32'h20);
        wr(`SRL_OFS_CMD, 32'd100, `SRL_RESP_OKAY);
        rd(`SRL_OFS_ACTPOS, d, r);
        chk(d, 32'd100);
        fwd_travel_end <= 1'b0;
        @(posedge aclk);
        wr(`SRL_OFS_CMD, 32'd200, `SRL_RESP_OKAY);
        repeat (4) @(posedge aclk);
        st(32'h73, {25'h0, sel, 2'b01, 2'b00, 2'b10});
        chk({30'h0, stop_state}, {30'h0, SRL_ALARM});
        wr(`SRL_OFS_CMD, 32'd300, `SRL_RESP_SLVERR);
        wr(`SRL_OFS_CTRL, 32'h2, `SRL_RESP_OKAY);
        rd(`SRL_OFS_CTRL, d, r);
        chk(d & 32'h7, 32'h0);
        wr(`SRL_OFS_CTRL, 32'h60, `SRL_RESP_OKAY);
        st(32'h98, 32'h08);
        // upper end still open: only commands away from it may move the axis
        for (int k = 1; k < 6; k++) begin
            if (k != 2) begin
                wr(`SRL_OFS_CTRL, k, `SRL_RESP_OKAY);
                wr(`SRL_OFS_CMD, 32'd150, `SRL_RESP_SLVERR);
                wr(`SRL_OFS_CMD, 32'hffffff00 - k, `SRL_RESP_OKAY);
                rd(`SRL_OFS_ACTPOS, d, r);
                chk(d, 32'hffffff00 - k);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 16; i++) begin
            sensor_source_select <= i[3];
            direction_select <= i[2];
            fwd_travel_end <= i[1];
            rev_travel_end <= i[0];
            home_prox_pin <= i[0];
            wr(`SRL_OFS_LIMIT, {29'h0, !i[0], i[0], i[1]}, `SRL_RESP_OKAY);
            repeat (6) @(posedge aclk);
            up = i[3] ? i[1] : (i[2] ? i[0] : i[1]);
            lo = i[3] ? i[0] : (i[2] ? i[1] : i[0]);
            st(32'h0f, {28'h0, !(up && lo), i[3] ^ i[0], lo, up});
            ms(!(up && lo));
        end
        sensor_source_select <= 1'b0;
        direction_select <= 1'b0;
        fwd_travel_end <= 1'b0;
        rev_travel_end <= 1'b0;
        auto_on_select <= 1'b1;
        repeat (8) @(posedge aclk);
        st(32'h0f, 32'h07);
        ms(1'b0);
        auto_on_select <= 1'b0;
        fwd_travel_end <= 1'b1;
        rev_travel_end <= 1'b1;
        for (int m = 0; m < 6; m++) begin
            wr(`SRL_OFS_CTRL, m, `SRL_RESP_OKAY);
            rd(`SRL_OFS_CTRL, d, r);
            chk(d & 32'h7, m);
            chk({31'h0, u_srl_link_if.csp_mode}, {31'h0, m == 0});
        end
        wr(8'h20, 32'h1, `SRL_RESP_SLVERR);
        rd(8'h24, d, r);
        chk({r, d[29:0]}, {`SRL_RESP_SLVERR, 30'h0});
        ov(1'b0);
        ov(1'b1);
        final_report();
    end
endmodule // tb
